// >>> bench/nff_tag_model.sv
// Model of the card or target on the far side of the RF field.
// Assumes the bench calls its tasks; it drives demodulated bits and the field detector level.
`timescale 1ns/1ps
`default_nettype none
module nff_tag_model (
  input wire logic i_mclk,
  output logic o_rx_bit,
  output logic o_ext_field
);
  // The demodulator output is a driven level, so an unmodulated field reads as zero.
  initial begin
    o_rx_bit = 1'b0;
    o_ext_field = 1'b0;
  end

  // Replies at the bit period the reader used, since both directions share one rate.
  // The length byte of a reply is sent as given; the bench also sends one below 2 to provoke a frame error.
  task automatic send(input logic [7:0] bytes[$], input int zeros, input int per);
    @(negedge i_mclk);
    for (int i = 0; i < zeros; i++) begin
      o_rx_bit = 1'b0;
      repeat (per) @(negedge i_mclk);
    end
    foreach (bytes[k]) begin
      for (int i = 7; i >= 0; i--) begin
        o_rx_bit = bytes[k][i];
        repeat (per) @(negedge i_mclk);
      end
    end
    o_rx_bit = 1'b0;
  endtask

  // Another field source nearby, sensed by the collision-avoidance detector.
  task automatic set_field(input logic on);
    @(negedge i_mclk);
    o_ext_field = on;
  endtask
endmodule // nff_tag_model
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench of the frame formatter: field-on, refusals, framed transmit and reply.
// Assumes the design package, its header and the tag model are compiled beforehand.
`timescale 1ns/1ps
`default_nettype none
module tb_top import nff_pkg::*; ;
  localparam int CA = 20;
  localparam int GD = 40;
  logic i_mclk, i_srst, cmd_tx, cmd_on, cmd_off, rx_bit, ext_field;
  logic fifo_rd, fifo_wr, tx_bit, tx_en, tx_act, rx_act;
  logic [7:0] fifo_head, fifo_wdata;
  nff_cfg_s cfg;
  nff_irq_s irq;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  int failures, checks, n_pop, n_txd, n_rxd, n_cad, n_cac, n_sfe, n_crc, n_fer, n;

  nff_frame_formatter #(.CA_CYC(CA), .GUARD_CYC(GD)) dut (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_cfg(cfg), .i_cmd_tx_crc(cmd_tx), .i_cmd_field_on(cmd_on), .i_cmd_field_off(cmd_off),
    .i_ext_field(ext_field), .i_rx_bit(rx_bit), .i_fifo_rdata(fifo_head), .o_fifo_rd(fifo_rd),
    .o_fifo_wr(fifo_wr), .o_fifo_wdata(fifo_wdata), .o_tx_bit(tx_bit), .o_tx_en(tx_en),
    .o_tx_active(tx_act), .o_rx_active(rx_act), .o_irq(irq));
  nff_tag_model tag (.i_mclk(i_mclk), .o_rx_bit(rx_bit), .o_ext_field(ext_field));

  initial i_mclk = 1'b0;
  always #5 i_mclk = ~i_mclk;

  // Show-ahead FIFO in the host's place; the head is refreshed off the sampling edge.
  always @(negedge i_mclk) fifo_head <= (txq.size() != 0) ? txq[0] : 8'h00;
  always @(posedge i_mclk) begin
    if (!i_srst) begin
      if (fifo_rd === 1'b1) begin
        n_pop++;
        if (txq.size() != 0) void'(txq.pop_front());
      end
      if (fifo_wr === 1'b1) rxq.push_back(fifo_wdata);
      n_txd += int'(irq.tx_done);
      n_rxd += int'(irq.rx_done);
      n_cad += int'(irq.ca_done);
      n_cac += int'(irq.ca_collision);
      n_sfe += int'(irq.soft_frame_err);
      n_crc += int'(irq.crc_err);
      n_fer += int'(irq.frame_err);
    end
  end

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'h0000;
    foreach (b[k]) begin
      c = c ^ {b[k], 8'h00};
      repeat (8) c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
    end
    return c;
  endfunction

  // Kind 0 transmits, 1 starts field-on, 2 switches the field off.
  task automatic issue(input int k);
    @(negedge i_mclk);
    cmd_tx = (k == 0);
    cmd_on = (k == 1);
    cmd_off = (k == 2);
    @(negedge i_mclk);
    cmd_tx = 1'b0;
    cmd_on = 1'b0;
    cmd_off = 1'b0;
  endtask

  task automatic set_cfg(input logic fel, input logic isoa, input logic [1:0] rate,
                         input logic tfe, input logic [7:0] cnt);
    @(negedge i_mclk);
    cfg = '0;
    cfg.mode_frame = fel;
    cfg.mode_iso_a = isoa;
    cfg.rate_sel = rate;
    cfg.transport_frame_enable = tfe;
    cfg.tx_byte_count = cnt;
  endtask

  task automatic refuse(input logic fel, input logic isoa, input logic [1:0] rate,
                        input logic tfe, input logic [7:0] cnt);
    set_cfg(fel, isoa, rate, tfe, cnt);
    issue(0);
    repeat (3) @(negedge i_mclk);
    chk_bit("refused tx active", 1'b0, tx_act);
  endtask

  // Samples each bit in mid period and compares whole bytes with the expected frame.
  task automatic frame_tx(input logic [7:0] first[$], input logic [7:0] pay[$],
                          input int pre, input int per);
    logic [7:0] body[$];
    logic [7:0] all[$];
    logic [15:0] c;
    logic [7:0] b;
    logic ones;
    int p0, t0;
    body = {8'(pay.size() + 1), pay};
    c = crc16(body);
    all = {first, body, c[15:8], c[7:0]};
    txq = pay;
    p0 = n_pop;
    t0 = n_txd;
    ones = 1'b0;
    issue(0);
    @(negedge i_mclk);
    chk_bit("tx active", 1'b1, tx_act);
    repeat (per + per / 2 - 1) @(negedge i_mclk);
    for (int i = 0; i < pre; i++) begin
      ones = ones | tx_bit;
      repeat (per) @(negedge i_mclk);
    end
    chk_bit("preamble", 1'b0, ones);
    foreach (all[k]) begin
      for (int i = 0; i < 8; i++) begin
        b = {b[6:0], tx_bit};
        repeat (per) @(negedge i_mclk);
      end
      chk_val("tx byte", {8'h00, all[k]}, {8'h00, b});
    end
    chk_val("fifo pops", 16'(pay.size()), 16'(n_pop - p0));
    chk_val("tx done", 16'h0001, 16'(n_txd - t0));
  endtask

  task automatic reply_rx(input logic [7:0] frame[$], input int zeros, input int per,
                          input logic [7:0] expq[$], input int ecrc, input int esfe);
    int r0, c0, s0;
    r0 = n_rxd;
    c0 = n_crc;
    s0 = n_sfe;
    rxq.delete();
    tag.send(frame, zeros, per);
    for (int i = 0; i < 2 * per && n_rxd == r0; i++) @(negedge i_mclk);
    chk_val("rx done", 16'h0001, 16'(n_rxd - r0));
    chk_val("fifo writes", 16'(expq.size()), 16'(rxq.size()));
    foreach (expq[k]) chk_val("rx byte", {8'h00, expq[k]}, {8'h00, rxq[k]});
    chk_val("crc error", 16'(ecrc), 16'(n_crc - c0));
    chk_val("soft frame error", 16'(esfe), 16'(n_sfe - s0));
  endtask

  initial begin
    #1600000;
    failures++;
    end_of_test();
  end

  initial begin
    logic [7:0] body[$];
    logic [15:0] c;
    int f0;
    i_srst = 1'b1;
    cmd_tx = 1'b0;
    cmd_on = 1'b0;
    cmd_off = 1'b0;
    cfg = '0;
    repeat (4) @(posedge i_mclk);
    @(negedge i_mclk);
    i_srst = 1'b0;
    // The host retries field-on after a collision and sends nothing meanwhile.
    tag.set_field(1'b1);
    issue(1);
    repeat (CA + 5) @(negedge i_mclk);
    chk_val("collision", 16'h0001, 16'(n_cac));
    chk_bit("tx en after collision", 1'b0, tx_en);
    chk_val("ca done after collision", 16'h0000, 16'(n_cad));
    tag.set_field(1'b0);
    issue(1);
    n = 0;
    while (tx_en !== 1'b1 && n < CA + 10) begin
      @(negedge i_mclk);
      n++;
    end
    chk_bit("field on time", 1'b1, n >= CA && n <= CA + 1);
    repeat (GD - 2) @(negedge i_mclk);
    chk_val("early ca done", 16'h0000, 16'(n_cad));
    repeat (5) @(negedge i_mclk);
    chk_val("ca done", 16'h0001, 16'(n_cad));
    issue(2);
    @(negedge i_mclk);
    chk_bit("field off", 1'b0, tx_en);
    refuse(1'b0, 1'b1, 2'h1, 1'b1, 8'h01);
    refuse(1'b1, 1'b0, 2'h2, 1'b0, 8'h00);
    refuse(1'b1, 1'b0, 2'h2, 1'b0, 8'hFF);
    // Frame mode at 424 kb/s with the default preamble selection.
    set_cfg(1'b1, 1'b0, 2'h2, 1'b0, 8'h01);
    frame_tx({8'hB2, 8'h4D}, {8'hA5}, 48, 235);
    body = {8'h02, 8'h3C};
    c = crc16(body);
    reply_rx({8'hB2, 8'h4D, body, c[15:8], c[7:0]}, 8, 235, body, 0, 0);
    // Shorter preamble selection, then a reply whose length byte is below the minimum.
    set_cfg(1'b1, 1'b0, 2'h2, 1'b0, 8'h01);
    cfg.preamble_len_sel_lo = 1'b1;
    frame_tx({8'hB2, 8'h4D}, {8'hC3}, 32, 235);
    f0 = n_fer;
    rxq.delete();
    tag.send({8'hB2, 8'h4D, 8'h01}, 0, 235);
    repeat (5) @(negedge i_mclk);
    chk_val("frame error", 16'h0001, 16'(n_fer - f0));
    chk_val("short length writes", 16'h0000, 16'(rxq.size()));
    chk_bit("rx active after short length", 1'b0, rx_act);
    // Transport framing at 106 kb/s; the reply has a bad start byte and a broken check.
    set_cfg(1'b0, 1'b1, 2'h0, 1'b1, 8'h01);
    frame_tx({8'hF0}, {8'h5A}, 0, 943);
    body = {8'h02, 8'h11};
    c = crc16(body) ^ 16'h0001;
    reply_rx({8'hE0, body, c[15:8], c[7:0]}, 0, 943, body, 1, 1);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire

// >>> design/nff_frame_formatter.sv
// Frame formatter: serial frame build, reply parse and initial field-on.
// Assumes a show-ahead FIFO outside, a demodulated bit input sampled at
// the bit rate, and a field detector level already compared to threshold.
//
// Contract
// R1: Frame mode runs at 212 or 424 kb/s, same rate both directions.
// R2: Frame is zero preamble, B2h, 4Dh, length byte, payload, two CRC bytes.
// R3: Length byte is valid only from 2 through 255.
// R4: Host loads only payload into FIFO and sets the byte count.
// R5: Two-bit selection picks preamble length, 48 bits by default.
// R6: Transmit-with-CRC sends preamble, sync, length, FIFO payload, own CRC.
// R7: Transmitted length byte equals byte count plus one.
// R8: After transmit ends, receiver hunts for the reply preamble.
// R9: After preamble and sync, length and payload go to FIFO, CRC checked.
// R10: Host uses 106 kb/s type A or frame mode at 212/424.
// R11: Passive initiator host uses field-on command, not transmitter bit.
// R12: Field-on checks for external field, then turns transmitter on.
// R13: After field on and guard time, collision-avoidance-done is raised.
// R14: External field found raises collision flag, transmitter stays off.
// R15: After collision the host retries field-on and does not transmit.
// R16: Host may run collision avoidance before any reader mode.
// R17: Transport framing needs enable bit plus type A at 106 kb/s.
// R18: Transport transmit sends F0h, length byte, FIFO data, own CRC.
// R19: Transport length byte is count plus one; FIFO holds data only.
// R20: Transport receive checks start byte, stores length and data.
// R21: Wrong start byte still stores data and raises soft framing error.
// R22: Received CRC bytes stay out of FIFO; failed check raises CRC error.
`timescale 1ns/1ps
`default_nettype none
`include "nff_params.svh"
module nff_frame_formatter import nff_pkg::*; #(
  parameter int unsigned CA_CYC = `NFF_CA_CYC,
  parameter int unsigned GUARD_CYC = `NFF_GUARD_CYC
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire nff_cfg_s i_cfg,
  input wire logic i_cmd_tx_crc,
  input wire logic i_cmd_field_on,
  input wire logic i_cmd_field_off,
  input wire logic i_ext_field,
  input wire logic i_rx_bit,
  input wire logic [7:0] i_fifo_rdata,
  output logic o_fifo_rd,
  output logic o_fifo_wr,
  output logic [7:0] o_fifo_wdata,
  output logic o_tx_bit,
  output logic o_tx_en,
  output logic o_tx_active,
  output logic o_rx_active,
  output nff_irq_s o_irq
);
  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
    crc_bit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `NFF_CRC_POLY : 16'h0000);
  endfunction

  function automatic logic [9:0] period_of(input logic [1:0] r);
    case (r)
      `NFF_RATE_CODE_212: period_of = 10'(`NFF_BIT_CYC(`NFF_RATE_212_KBPS));
      `NFF_RATE_CODE_424: period_of = 10'(`NFF_BIT_CYC(`NFF_RATE_424_KBPS));
      default: period_of = 10'(`NFF_BIT_CYC(`NFF_RATE_106_KBPS));
    endcase
  endfunction

  nff_tx_e tx_state;
  nff_rx_e rx_state;
  nff_fo_e fo_state;
  logic [9:0] div_cnt;
  logic bit_en;
  logic [7:0] tx_sreg;
  logic [2:0] tx_bcnt;
  logic [7:0] pre_cnt;
  logic [7:0] data_left;
  logic [7:0] tx_count_q;
  logic tx_tf;
  logic [15:0] tx_crc;
  logic rx_tf;
  logic [15:0] rx_win;
  logic [6:0] rx_sreg;
  logic [2:0] rx_bcnt;
  logic [7:0] rx_left;
  logic [15:0] rx_crc;
  logic [19:0] fo_cnt;
  logic irq_tx_done, irq_rx_done, irq_cat, irq_cac, irq_soft, irq_frame, irq_crc;

  // Frame mode is only legal at the two upper rates.
  wire frame_ok = i_cfg.mode_frame &&
    (i_cfg.rate_sel == `NFF_RATE_CODE_212 || i_cfg.rate_sel == `NFF_RATE_CODE_424); // see R1
  wire tf_active = i_cfg.transport_frame_enable && i_cfg.mode_iso_a &&
    i_cfg.rate_sel == `NFF_RATE_CODE_106; // see R17
  wire [8:0] len_calc = {1'b0, i_cfg.tx_byte_count} + 9'h001; // see R7 R19
  // A count whose length byte falls outside the legal range is refused.
  wire count_ok = len_calc >= {1'b0, `NFF_LEN_MIN} && len_calc <= {1'b0, `NFF_LEN_MAX}; // see R3
  wire tx_go = i_cmd_tx_crc && tx_state == TX_IDLE && fo_state == FO_IDLE &&
    (frame_ok || tf_active) && count_ok;
  wire [7:0] pre_len = i_cfg.preamble_len_sel_hi ?
    (i_cfg.preamble_len_sel_lo ? `NFF_PRE_LEN_SEL3 : `NFF_PRE_LEN_SEL2) :
    (i_cfg.preamble_len_sel_lo ? `NFF_PRE_LEN_SEL1 : `NFF_PRE_LEN_SEL0); // see R5
  wire tx_byte_end = bit_en && tx_bcnt == 3'h7;
  wire tx_crc_on = tx_state == TX_LEN || tx_state == TX_DATA;
  wire [15:0] tx_crc_nxt = crc_bit(tx_crc, tx_sreg[7]);
  wire tx_last = tx_byte_end && tx_state == TX_CRC2;
  wire [7:0] rx_byte = {rx_sreg, i_rx_bit};
  wire rx_byte_end = bit_en && rx_bcnt == 3'h7;
  wire [15:0] rx_win_nxt = {rx_win[14:0], i_rx_bit};
  wire [15:0] rx_crc_nxt = crc_bit(rx_crc, i_rx_bit);
  wire rx_sync_hit = rx_state == RX_HUNT && bit_en && !rx_tf &&
    rx_win_nxt == {`NFF_SYNC_HI, `NFF_SYNC_LO}; // see R9
  wire rx_sb_start = rx_state == RX_HUNT && bit_en && rx_tf && i_rx_bit;
  wire len_bad = rx_byte < `NFF_LEN_MIN; // see R3

  always_ff @(posedge i_mclk) begin
    if (i_srst || tx_go) begin
      div_cnt <= 10'h000;
      bit_en <= 1'b0;
    end else begin
      bit_en <= div_cnt == period_of(i_cfg.rate_sel) - 10'h001;
      div_cnt <= (div_cnt == period_of(i_cfg.rate_sel) - 10'h001) ? 10'h000 :
        div_cnt + 10'h001;
    end
  end

  // Transmit path: one byte register shifted out MSB first.
  always_ff @(posedge i_mclk) begin
    o_fifo_rd <= 1'b0;
    irq_tx_done <= 1'b0;
    if (i_srst) begin
      tx_state <= TX_IDLE;
      tx_sreg <= 8'h00;
      tx_bcnt <= 3'h0;
      pre_cnt <= 8'h00;
      data_left <= 8'h00;
      tx_count_q <= 8'h00;
      tx_tf <= 1'b0;
      tx_crc <= `NFF_CRC_INIT;
      o_tx_bit <= 1'b0;
      o_tx_active <= 1'b0;
    end else if (tx_go) begin
      tx_count_q <= i_cfg.tx_byte_count;
      tx_tf <= tf_active;
      tx_bcnt <= 3'h0;
      tx_crc <= `NFF_CRC_INIT;
      pre_cnt <= pre_len;
      o_tx_active <= 1'b1;
      tx_state <= tf_active ? TX_HDR : TX_PRE; // see R6 R18
      tx_sreg <= tf_active ? `NFF_START_BYTE : 8'h00; // see R18
    end else if (bit_en && tx_state == TX_PRE) begin
      o_tx_bit <= 1'b0; // see R2
      pre_cnt <= pre_cnt - 8'h01;
      if (pre_cnt == 8'h01) begin
        tx_state <= TX_SYNC1;
        tx_sreg <= `NFF_SYNC_HI; // see R2
      end
    end else if (bit_en && tx_state != TX_IDLE) begin
      o_tx_bit <= tx_sreg[7];
      tx_sreg <= {tx_sreg[6:0], 1'b0};
      tx_bcnt <= tx_bcnt + 3'h1;
      if (tx_crc_on) begin
        tx_crc <= tx_crc_nxt;
      end
      if (tx_byte_end) begin
        case (tx_state)
          TX_SYNC1: begin
            tx_state <= TX_HDR;
            tx_sreg <= `NFF_SYNC_LO; // see R2
          end
          TX_HDR: begin
            tx_state <= TX_LEN;
            tx_sreg <= tx_count_q + 8'h01; // see R7 R19
          end
          TX_LEN, TX_DATA: begin
            if (tx_state == TX_LEN || data_left != 8'h00) begin
              tx_state <= TX_DATA;
              tx_sreg <= i_fifo_rdata; // see R6 R4
              o_fifo_rd <= 1'b1;
              data_left <= (tx_state == TX_LEN ? tx_count_q : data_left) - 8'h01;
            end else begin
              tx_state <= TX_CRC1;
              tx_sreg <= tx_crc_nxt[15:8]; // see R6
            end
          end
          TX_CRC1: begin
            tx_state <= TX_CRC2;
            tx_sreg <= tx_crc[7:0];
          end
          default: begin
            tx_state <= TX_IDLE;
            o_tx_active <= 1'b0;
            irq_tx_done <= 1'b1;
          end
        endcase
      end
    end
  end

  // Receive path. There is no reply timeout here; a later transmit or
  // field-on command abandons the hunt.
  always_ff @(posedge i_mclk) begin
    o_fifo_wr <= 1'b0;
    irq_rx_done <= 1'b0;
    irq_soft <= 1'b0;
    irq_frame <= 1'b0;
    irq_crc <= 1'b0;
    if (i_srst || tx_go || i_cmd_field_on) begin
      rx_state <= RX_IDLE;
      rx_tf <= 1'b0;
      rx_win <= 16'h0000;
      rx_sreg <= 7'h00;
      rx_bcnt <= 3'h0;
      rx_left <= 8'h00;
      rx_crc <= `NFF_CRC_INIT;
      o_fifo_wdata <= 8'h00;
      o_rx_active <= 1'b0;
    end else if (tx_last) begin
      rx_state <= RX_HUNT; // see R8
      rx_tf <= tx_tf;
      rx_win <= 16'h0000;
      o_rx_active <= 1'b1;
    end else if (rx_sync_hit) begin
      rx_state <= RX_LEN;
      rx_bcnt <= 3'h0;
      rx_crc <= `NFF_CRC_INIT;
    end else if (rx_sb_start) begin
      rx_state <= RX_SB;
      rx_sreg <= 7'h01;
      rx_bcnt <= 3'h1;
    end else if (rx_state == RX_HUNT && bit_en) begin
      rx_win <= rx_win_nxt;
    end else if (bit_en && rx_state != RX_IDLE) begin
      rx_sreg <= rx_byte[6:0];
      rx_bcnt <= rx_bcnt + 3'h1;
      rx_crc <= rx_crc_nxt;
      if (rx_byte_end) begin
        case (rx_state)
          RX_SB: begin
            rx_state <= RX_LEN;
            rx_crc <= `NFF_CRC_INIT;
            irq_soft <= rx_byte != `NFF_START_BYTE; // see R20 R21
          end
          RX_LEN: begin
            if (len_bad) begin
              rx_state <= RX_IDLE;
              o_rx_active <= 1'b0;
              irq_frame <= 1'b1; // see R3
            end else begin
              rx_state <= RX_DATA;
              o_fifo_wr <= 1'b1; // see R9 R20
              o_fifo_wdata <= rx_byte;
              rx_left <= rx_byte - 8'h01;
            end
          end
          RX_DATA: begin
            o_fifo_wr <= 1'b1;
            o_fifo_wdata <= rx_byte;
            rx_left <= rx_left - 8'h01;
            if (rx_left == 8'h01) begin
              rx_state <= RX_CRC;
              rx_left <= 8'h02;
            end
          end
          RX_CRC: begin
            rx_left <= rx_left - 8'h01; // see R22
            if (rx_left == 8'h01) begin
              rx_state <= RX_IDLE;
              o_rx_active <= 1'b0;
              irq_rx_done <= 1'b1;
              irq_crc <= rx_crc_nxt != 16'h0000; // see R22
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  // Initial field-on: watch for a foreign field, then switch on and guard.
  always_ff @(posedge i_mclk) begin
    irq_cat <= 1'b0;
    irq_cac <= 1'b0;
    if (i_srst || i_cmd_field_off) begin
      fo_state <= FO_IDLE;
      fo_cnt <= 20'h00000;
      o_tx_en <= 1'b0;
    end else begin
      case (fo_state)
        FO_IDLE: begin
          if (i_cmd_field_on && tx_state == TX_IDLE) begin
            fo_state <= FO_CA;
            fo_cnt <= 20'h00000;
          end
        end
        FO_CA: begin
          fo_cnt <= fo_cnt + 20'h00001;
          if (i_ext_field) begin
            fo_state <= FO_IDLE;
            o_tx_en <= 1'b0; // see R14
            irq_cac <= 1'b1; // see R14
          end else if (fo_cnt == 20'(CA_CYC - 1)) begin
            fo_state <= FO_GUARD;
            fo_cnt <= 20'h00000;
            o_tx_en <= 1'b1; // see R12
          end
        end
        FO_GUARD: begin
          fo_cnt <= fo_cnt + 20'h00001;
          if (fo_cnt == 20'(GUARD_CYC - 1)) begin
            fo_state <= FO_IDLE;
            irq_cat <= 1'b1; // see R13
          end
        end
        default: fo_state <= FO_IDLE;
      endcase
    end
  end

  assign o_irq = '{tx_done: irq_tx_done, rx_done: irq_rx_done, ca_done: irq_cat,
    ca_collision: irq_cac, soft_frame_err: irq_soft, frame_err: irq_frame,
    crc_err: irq_crc};

  a_len_byte_value: assert property (@(posedge i_mclk) disable iff (i_srst) // see R7
    (tx_byte_end && tx_state == TX_HDR) |=> (tx_sreg == tx_count_q + 8'h01))
    else $error("length byte is not count plus one");
  a_sync_after_pre: assert property (@(posedge i_mclk) disable iff (i_srst) // see R2
    (bit_en && tx_state == TX_PRE && pre_cnt == 8'h01) |=>
    (tx_state == TX_SYNC1 && tx_sreg == `NFF_SYNC_HI))
    else $error("first sync byte missing after preamble");
  a_start_byte_tx: assert property (@(posedge i_mclk) disable iff (i_srst) // see R18
    (tx_go && tf_active) |=> (tx_state == TX_HDR && tx_sreg == `NFF_START_BYTE))
    else $error("transport frame does not begin with start byte");
  a_hunt_after_tx: assert property (@(posedge i_mclk) disable iff (i_srst) // see R8
    $rose(irq_tx_done) |-> (rx_state == RX_HUNT && o_rx_active))
    else $error("receiver not hunting after transmit");
  a_collision_off: assert property (@(posedge i_mclk) disable iff (i_srst) // see R14
    irq_cac |-> (!o_tx_en && fo_state == FO_IDLE))
    else $error("transmitter on after collision");
  a_cat_field_on: assert property (@(posedge i_mclk) disable iff (i_srst) // see R13
    irq_cat |-> (o_tx_en && $past(fo_state) == FO_GUARD))
    else $error("done flag without field on");
  a_crc_not_stored: assert property (@(posedge i_mclk) disable iff (i_srst) // see R22
    ($past(rx_state) == RX_CRC && rx_state == RX_CRC) |-> !o_fifo_wr)
    else $error("received crc written to fifo");
  a_short_len_drop: assert property (@(posedge i_mclk) disable iff (i_srst) // see R3
    (rx_byte_end && rx_state == RX_LEN && len_bad) |=> (irq_frame && !o_fifo_wr))
    else $error("short length byte accepted");
  a_bad_sb_soft: assert property (@(posedge i_mclk) disable iff (i_srst) // see R21
    (rx_byte_end && rx_state == RX_SB && rx_byte != `NFF_START_BYTE) |=>
    (irq_soft && rx_state == RX_LEN))
    else $error("bad start byte not flagged");
  a_bad_count_refused: assert property (@(posedge i_mclk) disable iff (i_srst) // see R3
    (i_cmd_tx_crc && tx_state == TX_IDLE && !count_ok) |=> (tx_state == TX_IDLE))
    else $error("out of range count started a frame");
  a_rate_legal: assert property (@(posedge i_mclk) disable iff (i_srst) // see R1 R17
    tx_go |-> (tf_active || i_cfg.rate_sel != `NFF_RATE_CODE_106))
    else $error("frame mode started at wrong rate");
endmodule // nff_frame_formatter
`default_nettype wire

// >>> design/nff_params.svh
// Constants of the NFC frame formatter: codes, lengths and timing counts.
// Assumes a 100 MHz core clock; times are converted to cycles here.
`ifndef NFF_PARAMS_SVH
`define NFF_PARAMS_SVH
`define NFF_CLK_MHZ 100
`define NFF_CLK_KHZ 100000
`define NFF_RATE_106_KBPS 106
`define NFF_RATE_212_KBPS 212
`define NFF_RATE_424_KBPS 424
`define NFF_RATE_CODE_106 2'h0
`define NFF_RATE_CODE_212 2'h1
`define NFF_RATE_CODE_424 2'h2
`define NFF_BIT_CYC(k) ((`NFF_CLK_KHZ) / (k))
`define NFF_SYNC_HI 8'hB2
`define NFF_SYNC_LO 8'h4D
`define NFF_START_BYTE 8'hF0
`define NFF_PRE_LEN_SEL0 8'h30
`define NFF_PRE_LEN_SEL1 8'h20
`define NFF_PRE_LEN_SEL2 8'h40
`define NFF_PRE_LEN_SEL3 8'h60
`define NFF_LEN_MIN 8'h02
`define NFF_LEN_MAX 8'hFF
`define NFF_CRC_INIT 16'h0000
`define NFF_CRC_POLY 16'h1021
`define NFF_CA_TIME_US 302
`define NFF_GUARD_TIME_US 5000
`define NFF_CA_CYC (`NFF_CA_TIME_US * `NFF_CLK_MHZ)
`define NFF_GUARD_CYC (`NFF_GUARD_TIME_US * `NFF_CLK_MHZ)
`endif

// >>> design/nff_pkg.sv
// Types shared by the NFC frame formatter and its surroundings.
// Assumes nothing beyond a SystemVerilog compiler.
package nff_pkg;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_PRE = 3'b001, TX_SYNC1 = 3'b010, TX_HDR = 3'b011,
    TX_LEN = 3'b100, TX_DATA = 3'b101, TX_CRC1 = 3'b110, TX_CRC2 = 3'b111
  } nff_tx_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_HUNT = 3'b001, RX_SB = 3'b010, RX_LEN = 3'b011,
    RX_DATA = 3'b100, RX_CRC = 3'b101
  } nff_rx_e;
  typedef enum logic [1:0] {
    FO_IDLE = 2'b00, FO_CA = 2'b01, FO_GUARD = 2'b10
  } nff_fo_e;
  typedef struct packed {
    logic mode_frame;
    logic mode_iso_a;
    logic [1:0] rate_sel;
    logic transport_frame_enable;
    logic preamble_len_sel_hi;
    logic preamble_len_sel_lo;
    logic [7:0] tx_byte_count;
  } nff_cfg_s;
  typedef struct packed {
    logic tx_done;
    logic rx_done;
    logic ca_done;
    logic ca_collision;
    logic soft_frame_err;
    logic frame_err;
    logic crc_err;
  } nff_irq_s;
endpackage
